// >>> ssef_pkg.sv
// Package: register map, field layout and constants for scale slew and freeze
package ssef_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [6:0] STANDBY_DELAY_ADDR   = 7'h15;
  localparam logic [6:0] FREEWHEEL_DELAY_ADDR = 7'h16;
  localparam logic [6:0] VELOCITY_LIMIT_ADDR  = 7'h17;
  localparam logic [6:0] RISE_INTERVAL_ADDR   = 7'h18;
  localparam logic [6:0] HOLD_INTERVAL_ADDR   = 7'h19;
  localparam logic [6:0] FALL_INTERVAL_ADDR   = 7'h1a;
  localparam logic [6:0] BOOST_DELAY_ADDR     = 7'h1b;
  localparam logic [6:0] SCALE_VALUES_ADDR    = 7'h06;
  localparam logic [6:0] CONTROL_ADDR         = 7'h05;
  localparam logic [6:0] EVENT_ADDR           = 7'h0e;
  localparam logic [6:0] VELOCITY_ADDR        = 7'h22;
  localparam logic [6:0] HALT_CONFIG_ADDR     = 7'h4e;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int HALT_DECEL_LSB   = 0;
  localparam int HALT_DECEL_W     = 24;
  localparam int HALT_SCALE_LSB   = 24;
  localparam int SCALE_W          = 8;
  localparam int HALT_EVENT_BIT   = 10;
  localparam int HOLD_SCALE_LSB   = 24;
  localparam int SECOND_SCALE_LSB = 16;
  localparam int FIRST_SCALE_LSB  = 8;
  localparam int BOOST_SCALE_LSB  = 0;
  localparam int CTL_HOLD_EN      = 0;
  localparam int CTL_DRIVE_EN     = 1;
  localparam int CTL_SECOND_EN    = 2;
  localparam int CTL_BOOST_ACC_EN = 3;
  localparam int CTL_RAMP_START   = 4;

  // ----------------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [31:0] REG_RESET    = 32'h0000_0000;
  localparam logic [7:0]  SCALE_RESET  = 8'h00;
  localparam int          HALT_FILTER  = 3;

endpackage : ssef_pkg

// >>> ssef_halt_filter.sv
// Emergency halt input filter with falling edge detection
module ssef_halt_filter
  import ssef_pkg::*;
#(
  parameter int SAMPLES = ssef_pkg::HALT_FILTER
)(
  input  wire logic i_clock,
  input  wire logic i_rst_b,
  input  wire logic i_halt_n,
  output logic      o_halt_low,
  output logic      o_halt_fall
);

  logic [SAMPLES-1:0] hist_q;
  logic               low_q;

  // ----------------------------------------------------------------------
  // Sample history; a glitch shorter than the window never counts
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      hist_q <= '1;
      low_q  <= 1'b0;
    end
    else
    begin
      hist_q <= {hist_q[SAMPLES-2:0], i_halt_n};
      if (hist_q == '0)
        low_q <= 1'b1;                            // [RULE12] [RULE16]
      else if (hist_q == '1)
        low_q <= 1'b0;
    end
  end

  assign o_halt_low  = low_q;
  assign o_halt_fall = (hist_q == '0) && !low_q;  // [RULE10]

  a_filter_three : assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (!i_halt_n) [*3] |=> ##1 low_q)               // [RULE12]
    else $error("halt low not recognised after three samples");

endmodule : ssef_halt_filter

// >>> ssef_step_timer.sv
// Step interval timer giving one pulse per elapsed interval
module ssef_step_timer #(
  parameter int W = 32
)(
  input  wire logic         i_clock,
  input  wire logic         i_rst_b,
  input  wire logic         i_run,
  input  wire logic [W-1:0] i_interval,
  output logic              o_tick
);

  logic [W-1:0] count_q;

  // ----------------------------------------------------------------------
  // Count cycles; restart whenever stopped so each phase starts fresh
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      count_q <= '0;
    else if (!i_run || o_tick)
      count_q <= '0;
    else
      count_q <= count_q + W'(1);
  end

  // Zero interval ticks every cycle: target taken at once
  assign o_tick = i_run && ((i_interval == '0) || (count_q + W'(1) >= i_interval));

endmodule : ssef_step_timer

// >>> ssef_core.sv
// Scale slew sequencer and emergency freeze with register port
// Contract
// RULE1 - In hold, step scale down one per hold interval until standstill scale
// RULE2 - Zero hold interval loads standstill scale at once
// RULE3 - Higher target: step up one per rise interval; interval at 0x18
// RULE4 - Zero rise interval takes higher target immediately
// RULE5 - Lower target: step down one per fall interval; interval at 0x1A
// RULE6 - Zero fall interval takes lower target immediately
// RULE7 - Boost, standby and freewheel timers use registers 0x1B, 0x15, 0x16
// RULE8 - Two drive scales, boost on acc: first scale below velocity limit
// RULE9 - Velocity through zero restarts acceleration phase and boost
// RULE10 - Falling halt input stops ramp at once as configured
// RULE11 - Halt low sets event bit 10, held until reset
// RULE12 - Halt low recognised after three consecutive low samples
// RULE13 - Freeze register bits 23:0 hold halt deceleration
// RULE14 - Freeze register bits 31:24 hold halt scale
// RULE15 - Freeze register written once after reset, only before ramp start
// RULE16 - Halt input always active low, polarity fixed
// RULE17 - Freeze register always readable
// RULE18 - Ramp registers stay readable while halt_latched_event
// RULE19 - Hold interval register at 0x19 sets cycles between down steps
// RULE20 - Halt deceleration is raw velocity change per cycle; zero stops hard
// RULE21 - Nonzero halt scale becomes active scale after halt event
// RULE22 - Zero halt scale keeps last scale permanently while halt_latched_event
// RULE23 - Later freeze register writes silently ignored until reset
module ssef_core
  import ssef_pkg::*;
#(
  parameter int DW = 32,
  parameter int SW = ssef_pkg::SCALE_W
)(
  input  wire logic                i_clock,
  input  wire logic                i_rst_b,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  input  wire logic [6:0]          i_addr,
  input  wire logic [DW-1:0]       i_wdata,
  input  wire logic                i_emergency_halt_n,
  input  wire logic signed [31:0]  i_current_velocity,
  output logic [DW-1:0]            o_rdata,
  output logic                     o_rvalid,
  output logic [SW-1:0]            o_actual_scale_level,
  output logic signed [31:0]       o_halt_velocity,
  output logic                     o_halt_latched_event
);
  import ssef_pkg::*;

  typedef enum logic [2:0] {ST_MOTION, ST_BOOST, ST_STANDBY, ST_HOLD, ST_FREE}
    ssef_phase_e;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [DW-1:0] ctl_q, scales_q, vlimit_q, rise_q, hold_q, fall_q;
  logic [DW-1:0] boost_dly_q, stby_dly_q, free_dly_q, halt_cfg_q;
  logic          halt_locked_q, ramp_started_q, halt_event_q;
  logic [SW-1:0] scale_q, target_d, halt_latched_event_scale_q;
  logic signed [31:0] halt_vel_q, vel_prev_q;
  logic [DW-1:0] rdata_q;
  logic          rvalid_q;
  logic [DW-1:0] phase_cnt_q;
  ssef_phase_e   phase_q;
  logic          halt_low, halt_fall;

  // Absolute value used by the drive scale comparison, the acceleration test and halt deceleration
  function automatic logic [31:0] abs_vel(input logic signed [31:0] v);
    abs_vel = v[31] ? 32'(-v) : 32'(v);
  endfunction : abs_vel

  ssef_halt_filter #(.SAMPLES(HALT_FILTER)) u_filter (
    .i_clock     (i_clock),
    .i_rst_b     (i_rst_b),
    .i_halt_n    (i_emergency_halt_n),
    .o_halt_low  (halt_low),
    .o_halt_fall (halt_fall)
  );

  // ----------------------------------------------------------------------
  // Register writes; freeze config is write-once before any ramp start
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ctl_q <= REG_RESET; scales_q <= REG_RESET; vlimit_q <= REG_RESET;
      rise_q <= REG_RESET; hold_q <= REG_RESET; fall_q <= REG_RESET;
      boost_dly_q <= REG_RESET; stby_dly_q <= REG_RESET; free_dly_q <= REG_RESET;
      halt_cfg_q <= REG_RESET;
      halt_locked_q <= 1'b0;
    end
    else if (i_wr)
    begin
      unique case (i_addr)
        CONTROL_ADDR:         ctl_q <= i_wdata;
        SCALE_VALUES_ADDR:    scales_q <= i_wdata;
        VELOCITY_LIMIT_ADDR:  vlimit_q <= i_wdata;
        RISE_INTERVAL_ADDR:   rise_q <= i_wdata;      // [RULE3]
        HOLD_INTERVAL_ADDR:   hold_q <= i_wdata;      // [RULE19]
        FALL_INTERVAL_ADDR:   fall_q <= i_wdata;      // [RULE5]
        BOOST_DELAY_ADDR:     boost_dly_q <= i_wdata; // [RULE7]
        STANDBY_DELAY_ADDR:   stby_dly_q <= i_wdata;  // [RULE7]
        FREEWHEEL_DELAY_ADDR: free_dly_q <= i_wdata;  // [RULE7]
        HALT_CONFIG_ADDR:
          if (!halt_locked_q && !ramp_started_q)
          begin
            halt_cfg_q    <= i_wdata;                 // [RULE13] [RULE14] [RULE15]
            halt_locked_q <= 1'b1;
          end                                         // [RULE23]
        default: ;
      endcase
    end
  end

  // Ramp start: velocity leaves zero or start strobe in control word
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      ramp_started_q <= 1'b0;
    else if (i_current_velocity != 0 || ctl_q[CTL_RAMP_START])
      ramp_started_q <= 1'b1;                         // [RULE15]
  end

  // ----------------------------------------------------------------------
  // Halt event latch, sticky until reset
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      halt_event_q   <= 1'b0;
      halt_latched_event_scale_q <= SCALE_RESET;
    end
    else if (halt_fall && !halt_event_q)
    begin
      halt_event_q   <= 1'b1;                         // [RULE11] [RULE10]
      halt_latched_event_scale_q <= scale_q;                      // [RULE22]
    end
  end

  // Velocity during freeze: raw per-cycle decrement, zero gives hard stop
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      halt_vel_q <= '0;
    else if (!halt_event_q && !halt_fall)
      halt_vel_q <= i_current_velocity;
    else if (halt_cfg_q[HALT_DECEL_LSB +: HALT_DECEL_W] == '0)
      halt_vel_q <= '0;                               // [RULE20]
    else if (abs_vel(halt_vel_q) <= 32'(halt_cfg_q[HALT_DECEL_LSB +: HALT_DECEL_W]))
      halt_vel_q <= '0;
    else if (halt_vel_q[31])
      halt_vel_q <= halt_vel_q + $signed({8'h00, halt_cfg_q[23:0]}); // [RULE20]
    else
      halt_vel_q <= halt_vel_q - $signed({8'h00, halt_cfg_q[23:0]});
  end

  // ----------------------------------------------------------------------
  // Scale phase: boost after start, standby and freewheel timers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      phase_q     <= ST_HOLD;
      phase_cnt_q <= '0;
      vel_prev_q  <= '0;
    end
    else
    begin
      vel_prev_q  <= i_current_velocity;
      phase_cnt_q <= phase_cnt_q + DW'(1);
      unique case (phase_q)
        ST_MOTION:
          if (i_current_velocity == 0)
          begin
            phase_q <= ST_STANDBY; phase_cnt_q <= '0;
          end
        ST_BOOST:
          if (i_current_velocity == 0)
          begin
            phase_q <= ST_STANDBY; phase_cnt_q <= '0;
          end
          else if (phase_cnt_q >= boost_dly_q)        // [RULE7]
            phase_q <= ST_MOTION;
        ST_STANDBY, ST_HOLD, ST_FREE:
          if (i_current_velocity != 0)
          begin
            phase_q <= ST_BOOST; phase_cnt_q <= '0;
          end
          else if (phase_q == ST_STANDBY && phase_cnt_q >= stby_dly_q)
          begin
            phase_q <= ST_HOLD; phase_cnt_q <= '0;    // [RULE7]
          end
          else if (phase_q == ST_HOLD && phase_cnt_q >= free_dly_q)
            phase_q <= ST_FREE;                       // [RULE7]
      endcase
    end
  end

  // Acceleration while magnitude grows, or at a zero crossing
  logic accel;
  assign accel = (abs_vel(i_current_velocity) > abs_vel(vel_prev_q))
               || (i_current_velocity[31] != vel_prev_q[31]);      // [RULE9]

  // ----------------------------------------------------------------------
  // Target scale selection
  // ----------------------------------------------------------------------
  always_comb
  begin
    target_d = scale_q;
    unique case (phase_q)
      ST_HOLD:    target_d = scales_q[HOLD_SCALE_LSB +: SW];
      ST_FREE:    target_d = SCALE_RESET;
      ST_STANDBY: target_d = scale_q;
      ST_BOOST:   target_d = scales_q[BOOST_SCALE_LSB +: SW];
      ST_MOTION:
        if (ctl_q[CTL_BOOST_ACC_EN] && accel)
          target_d = scales_q[BOOST_SCALE_LSB +: SW];              // [RULE9]
        else if (ctl_q[CTL_SECOND_EN]
                 && abs_vel(i_current_velocity) >= vlimit_q)
          target_d = scales_q[SECOND_SCALE_LSB +: SW];
        else if (ctl_q[CTL_DRIVE_EN])
          target_d = scales_q[FIRST_SCALE_LSB +: SW];              // [RULE8]
    endcase
    if (halt_event_q)
      target_d = (halt_cfg_q[HALT_SCALE_LSB +: SW] != '0)
               ? halt_cfg_q[HALT_SCALE_LSB +: SW] : halt_latched_event_scale_q; // [RULE21] [RULE22]
  end

  logic up_need, dn_need, up_tick, dn_tick, hold_dn;
  assign up_need = !halt_event_q && target_d > scale_q;
  assign dn_need = !halt_event_q && target_d < scale_q;
  assign hold_dn = phase_q == ST_HOLD;

  ssef_step_timer #(.W(DW)) u_up (
    .i_clock (i_clock), .i_rst_b (i_rst_b), .i_run (up_need),
    .i_interval (rise_q), .o_tick (up_tick)
  );
  ssef_step_timer #(.W(DW)) u_dn (
    .i_clock (i_clock), .i_rst_b (i_rst_b), .i_run (dn_need),
    .i_interval (hold_dn ? hold_q : fall_q), .o_tick (dn_tick)
  );

  // ----------------------------------------------------------------------
  // Actual scale slew; zero interval jumps straight to the target
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      scale_q <= SCALE_RESET;
    else if (halt_event_q)
      scale_q <= target_d;                            // [RULE21] [RULE22]
    else if (up_tick)
      scale_q <= (rise_q == '0) ? target_d : scale_q + SW'(1);     // [RULE3] [RULE4]
    else if (dn_tick && hold_dn)
      scale_q <= (hold_q == '0) ? target_d : scale_q - SW'(1);     // [RULE1] [RULE2]
    else if (dn_tick)
      scale_q <= (fall_q == '0) ? target_d : scale_q - SW'(1);     // [RULE5] [RULE6]
  end

  // ----------------------------------------------------------------------
  // Read port; everything stays readable while halt_latched_event
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= i_rd;
      if (i_rd)
      begin
        rdata_q <= '0;
        unique case (i_addr)
          CONTROL_ADDR:         rdata_q <= ctl_q;
          SCALE_VALUES_ADDR:    rdata_q <= scales_q;
          VELOCITY_LIMIT_ADDR:  rdata_q <= vlimit_q;
          RISE_INTERVAL_ADDR:   rdata_q <= rise_q;
          HOLD_INTERVAL_ADDR:   rdata_q <= hold_q;
          FALL_INTERVAL_ADDR:   rdata_q <= fall_q;
          BOOST_DELAY_ADDR:     rdata_q <= boost_dly_q;
          STANDBY_DELAY_ADDR:   rdata_q <= stby_dly_q;
          FREEWHEEL_DELAY_ADDR: rdata_q <= free_dly_q;
          HALT_CONFIG_ADDR:     rdata_q <= halt_cfg_q;             // [RULE17]
          EVENT_ADDR:           rdata_q[HALT_EVENT_BIT] <= halt_event_q;
          VELOCITY_ADDR:        rdata_q <= halt_event_q ? halt_vel_q
                                                        : i_current_velocity; // [RULE18]
          default: ;
        endcase
      end
    end
  end

  assign o_rdata              = rdata_q;
  assign o_rvalid             = rvalid_q;
  assign o_actual_scale_level = scale_q;
  assign o_halt_velocity      = halt_vel_q;
  assign o_halt_latched_event             = halt_event_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_halt_write;
    i_wr && i_addr == HALT_CONFIG_ADDR;
  endsequence

  a_event_sticky : assert property (@(posedge i_clock) disable iff (!i_rst_b)
    halt_event_q |=> halt_event_q)                                 // [RULE11]
    else $error("halt event dropped before reset");
  a_event_set : assert property (@(posedge i_clock) disable iff (!i_rst_b)
    halt_fall |=> halt_event_q)                                    // [RULE11]
    else $error("halt event not raised");
  a_cfg_locked : assert property (@(posedge i_clock) disable iff (!i_rst_b)
    s_halt_write ##0 (halt_locked_q || ramp_started_q) |=> $stable(halt_cfg_q)) // [RULE23]
    else $error("freeze register changed after lock");
  a_cfg_first : assert property (@(posedge i_clock) disable iff (!i_rst_b)
    s_halt_write ##0 (!halt_locked_q && !ramp_started_q) |=> halt_cfg_q == $past(i_wdata)) // [RULE15]
    else $error("first freeze write not taken");
  a_rise_zero : assert property (@(posedge i_clock) disable iff (!i_rst_b)
    up_need && rise_q == '0 && !halt_fall |=> scale_q == $past(target_d)) // [RULE4]
    else $error("zero rise interval not immediate");
  a_step_one : assert property (@(posedge i_clock) disable iff (!i_rst_b)
    up_tick && rise_q != '0 && !halt_event_q |=> scale_q == $past(scale_q) + SW'(1)) // [RULE3]
    else $error("rise step not one");
  a_hold_zero : assert property (@(posedge i_clock) disable iff (!i_rst_b)
    dn_need && hold_dn && hold_q == '0 && !halt_fall |=> scale_q == $past(target_d)) // [RULE2]
    else $error("zero hold interval not immediate");
  a_freeze_scale : assert property (@(posedge i_clock) disable iff (!i_rst_b)
    halt_event_q && halt_cfg_q[31:24] != '0 |=> scale_q == halt_cfg_q[31:24]) // [RULE21]
    else $error("halt scale not applied");
  a_hard_stop : assert property (@(posedge i_clock) disable iff (!i_rst_b)
    halt_event_q && halt_cfg_q[23:0] == '0 |=> halt_vel_q == 0)   // [RULE20]
    else $error("hard stop not taken");

endmodule : ssef_core

// >>> ssef_halt_src.sv
// Partner model: external party that drives the emergency halt line
module ssef_halt_src
(
  input  wire logic i_clock,
  output logic      o_emergency_halt_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Halt line driver
  // ----------------------------------------------------------------------
  // Idle high, since the line is low active with fixed polarity
  initial o_emergency_halt_n = 1'b1;

  // Hold low for a whole number of cycles, changed at falling edges only
  task automatic pulse(input int cycles);
    @(negedge i_clock);
    o_emergency_halt_n = 1'b0;
    repeat (cycles) @(negedge i_clock);
    o_emergency_halt_n = 1'b1;
  endtask : pulse
endmodule : ssef_halt_src

// >>> ssef_core_tb.sv
// Self-checking testbench for the scale slew and freeze core
`define SSEF_CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  $display("ERROR %0t: got %h want %h", $time, (a), (b)); miscompares++; end end
module ssef_core_tb;
  import ssef_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic [6:0] a; logic [31:0] w; logic [31:0] r;} ssef_row_s;

  logic               i_clock = 1'b0;
  logic               i_rst_b = 1'b0;
  logic               i_wr = 1'b0;
  logic               i_rd = 1'b0;
  logic [6:0]         i_addr = 7'h00;
  logic [31:0]        i_wdata = 32'h0;
  logic signed [31:0] i_current_velocity = 32'sh0;
  logic               halt_n;
  logic [31:0]        o_rdata;
  logic               o_rvalid;
  logic [7:0]         o_actual_scale_level;
  logic signed [31:0] o_halt_velocity;
  logic               o_halt_latched_event;
  int                 miscompares = 0;
  int                 check_count = 0;
  int                 n;
  int                 steps;
  logic [31:0]        rd_q;
  logic signed [31:0] v1;
  ssef_row_s          rows [7];

  // Clock at 20 MHz
  always #25 i_clock = ~i_clock;

  ssef_halt_src ssef_halt_src_inst (.i_clock(i_clock), .o_emergency_halt_n(halt_n));

  ssef_core ssef_core_inst (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_emergency_halt_n(halt_n), .i_current_velocity(i_current_velocity),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_actual_scale_level(o_actual_scale_level),
    .o_halt_velocity(o_halt_velocity), .o_halt_latched_event(o_halt_latched_event));

  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(negedge i_clock);
    i_wr = 1'b1;
    i_addr = a;
    i_wdata = d;
    @(negedge i_clock);
    i_wr = 1'b0;
  endtask : wr

  // Answer is registered at the taking edge, so sample at the next fall
  task automatic rd(input logic [6:0] a);
    @(negedge i_clock);
    i_rd = 1'b1;
    i_addr = a;
    @(negedge i_clock);
    i_rd = 1'b0;
    rd_q = o_rdata;
    `SSEF_CHK(o_rvalid, 1'b1)
  endtask : rd

  task automatic do_reset();
    @(negedge i_clock);
    i_rst_b = 1'b0;
    repeat (3) @(negedge i_clock);
    i_rst_b = 1'b1;
  endtask : do_reset

  // Counts cycles and level changes until the scale reaches a value
  task automatic wait_scale(input logic [7:0] want);
    logic [7:0] prev;
    n = 0;
    steps = 0;
    prev = o_actual_scale_level;
    while (o_actual_scale_level !== want && n < 400)
    begin
      @(negedge i_clock);
      n++;
      if (o_actual_scale_level !== prev)
        steps++;
      prev = o_actual_scale_level;
    end
  endtask : wait_scale

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  // Watchdog well beyond the expected few hundred cycles
  initial
  begin
    #(20000 * 50);
    miscompares++;
    conclude();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    rows = '{'{RISE_INTERVAL_ADDR, 32'h5, 32'h5}, '{FALL_INTERVAL_ADDR, 32'h3, 32'h3},
             '{HOLD_INTERVAL_ADDR, 32'h2, 32'h2}, '{VELOCITY_LIMIT_ADDR, 32'h64, 32'h64},
             '{HALT_CONFIG_ADDR, 32'h4000_0010, 32'h4000_0010},
             '{HALT_CONFIG_ADDR, 32'h1234_5678, 32'h4000_0010},
             '{7'h7f, 32'hff, 32'h0}};
    repeat (3) @(negedge i_clock);
    i_rst_b = 1'b1;
    // Register rows; the second freeze write must leave the first in place
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      `SSEF_CHK(rd_q, rows[i].r)
    end
    // Rise from zero in single steps, one per five cycles
    wr(SCALE_VALUES_ADDR, 32'h0000_2000);
    wr(CONTROL_ADDR, 32'h2);
    i_current_velocity = 32'sd10;
    wait_scale(8'h20);
    `SSEF_CHK(steps, 32)
    `SSEF_CHK(n >= 31 * 5, 1'b1)
    // Lower target: sixteen single steps, one per three cycles
    wr(SCALE_VALUES_ADDR, 32'h0000_1000);
    wait_scale(8'h10);
    `SSEF_CHK(steps, 16)
    `SSEF_CHK(n >= 15 * 3 && n < 60, 1'b1)
    // Zero fall interval jumps straight to the lower target
    wr(FALL_INTERVAL_ADDR, 32'h0);
    wr(SCALE_VALUES_ADDR, 32'h0000_0800);
    wait_scale(8'h08);
    `SSEF_CHK(steps, 1)
    `SSEF_CHK(n <= 3, 1'b1)
    // Standstill: down to the hold scale one step per two cycles
    wr(SCALE_VALUES_ADDR, 32'h0200_0800);
    wr(FREEWHEEL_DELAY_ADDR, 32'h40);
    i_current_velocity = 32'sd0;
    wait_scale(8'h02);
    `SSEF_CHK(steps, 6)
    `SSEF_CHK(n >= 5 * 2 && n < 20, 1'b1)
    // Zero hold interval takes a new hold scale in one jump
    wr(HOLD_INTERVAL_ADDR, 32'h0);
    wr(SCALE_VALUES_ADDR, 32'h0100_0800);
    wait_scale(8'h01);
    `SSEF_CHK(steps, 1)
    `SSEF_CHK(n <= 3, 1'b1)
    // Hold scale stands until the freewheel timer runs out
    wait_scale(8'h00);
    `SSEF_CHK(n > 30 && n < 70, 1'b1)
    // Two low samples are filtered out
    ssef_halt_src_inst.pulse(2);
    repeat (6) @(negedge i_clock);
    `SSEF_CHK(o_halt_latched_event, 1'b0)
    // Three low samples latch the event, which then outlives the pulse
    i_current_velocity = 32'sd200;
    ssef_halt_src_inst.pulse(3);
    repeat (3) @(negedge i_clock);
    `SSEF_CHK(o_halt_latched_event, 1'b1)
    v1 = o_halt_velocity;
    @(negedge i_clock);
    `SSEF_CHK(v1 - o_halt_velocity, 32'sd16)
    wait_scale(8'h40);
    `SSEF_CHK(n <= 6, 1'b1)
    rd(EVENT_ADDR);
    `SSEF_CHK(rd_q[HALT_EVENT_BIT], 1'b1)
    rd(HALT_CONFIG_ADDR);
    `SSEF_CHK(rd_q, 32'h4000_0010)
    rd(RISE_INTERVAL_ADDR);
    `SSEF_CHK(rd_q, 32'h5)
    repeat (20) @(negedge i_clock);
    `SSEF_CHK(o_halt_latched_event, 1'b1)
    `SSEF_CHK(o_halt_velocity, 32'sd0)
    // Reset clears the latch and re-arms the one-time write
    do_reset();
    `SSEF_CHK(o_halt_latched_event, 1'b0)
    `SSEF_CHK(o_actual_scale_level, SCALE_RESET)
    rd(HALT_CONFIG_ADDR);
    `SSEF_CHK(rd_q, REG_RESET)
    // With a ramp running the freeze write is refused
    wr(HALT_CONFIG_ADDR, 32'h0000_0020);
    rd(HALT_CONFIG_ADDR);
    `SSEF_CHK(rd_q, REG_RESET)
    i_current_velocity = 32'sd0;
    do_reset();
    // Zero freeze scale keeps the scale that was in force
    wr(HALT_CONFIG_ADDR, 32'h0000_0000);
    wr(SCALE_VALUES_ADDR, 32'h0000_0600);
    wr(CONTROL_ADDR, 32'h2);
    i_current_velocity = 32'sd10;
    wait_scale(8'h06);
    `SSEF_CHK(steps, 1)
    ssef_halt_src_inst.pulse(4);
    // A higher drive scale written while halt_latched_event must not move the level
    wr(SCALE_VALUES_ADDR, 32'h0000_0900);
    repeat (10) @(negedge i_clock);
    `SSEF_CHK(o_actual_scale_level, 8'h06)
    `SSEF_CHK(o_halt_velocity, 32'sd0)
    conclude();
  end
endmodule : ssef_core_tb
